// file: asf_pkg.sv
// constants for the axis status and fault parameter bank
// assumes a single 50 MHz clock and the parameter command port of asf_top
`default_nettype none
package asf_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [7:0] NUM_COIL_OPTION = 8'hCC;
  localparam logic [7:0] NUM_LOAD = 8'hCE;
  localparam logic [7:0] NUM_EXT_FLAGS = 8'hCF;
  localparam logic [7:0] NUM_DRV_FLAGS = 8'hD0;
  localparam logic [7:0] NUM_ENC_COUNT = 8'hD1;
  localparam logic [7:0] NUM_ZERO_CLEAR = 8'hD2;
  localparam logic [7:0] NUM_MAX_DEV = 8'hD4;
  // standstill coil option encodings
  typedef enum logic [1:0] {
    ASF_COIL_NORMAL = 2'b00,
    ASF_COIL_FREEWHEEL = 2'b01,
    ASF_COIL_SHORT_LOW = 2'b10,
    ASF_COIL_SHORT_HIGH = 2'b11
  } asf_coil_type;
  // extended flag positions
  localparam int EXT_STALL_BIT = 0;
  localparam int EXT_DEV_BIT = 1;
  // driver fault flag positions
  localparam int DRV_STALL_BIT = 0;
  localparam int DRV_OT_BIT = 1;
  localparam int DRV_OTPW_BIT = 2;
  localparam int DRV_SHORT_A_BIT = 3;
  localparam int DRV_SHORT_B_BIT = 4;
  localparam int DRV_OPEN_A_BIT = 5;
  localparam int DRV_OPEN_B_BIT = 6;
  localparam int DRV_STANDSTILL_BIT = 7;
  // standstill window in clock cycles (2^20)
  localparam int unsigned STANDSTILL_CYCLES = 32'h0010_0000;
  // reset values
  localparam logic [1:0] COIL_OPTION_RESET = 2'h0;
  localparam logic [31:0] ENC_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] MAX_DEV_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// file: asf_sync.sv
// three-stage input synchroniser with per-bit agreement filter
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module asf_sync #(
  parameter int W = 7
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [W-1:0] din, // asynchronous inputs
  output var logic [W-1:0] dout // filtered synchronous outputs
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      dout <= '0;
    else
      dout <= (s3_reg & ~(s2_reg ^ s3_reg)) | (dout & (s2_reg ^ s3_reg));
  end
endmodule
`default_nettype wire

// file: asf_top.sv
// axis status and fault parameter bank with internal encoder counter
// assumes driver status pins are asynchronous; step, encoder and command
// strobes come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
// Function
// - coil option 0 is normal, 1 freewheel, 2 low-side short, 3 high-side short.
// - the coil option only acts while standby current is zero and quiet chopper is active.
// - the load value is read-only and returns the live 10-bit load measurement.
// - extended flags are read-only, bit value 1 stall and 2 deviation, both may be set.
// - extended flags clear after being read and after a motion command.
// - driver flags bit 0 stall, bit 1 overtemperature shutdown, bit 2 pre-warning.
// - driver flags bits 3 and 4 show a short to ground on coil A and B.
// - driver flags bits 5 and 6 show open load on coil A and B.
// - driver flag bit 7 shows standstill when no step pulse came in the last 2^20 cycles.
// - the encoder count is a signed 32-bit value that software can read and write.
// - with clear-on-zero armed the encoder count clears at the encoder zero position.
// - after that clear the clear-on-zero control returns to 0 by itself.
// - the motor stops when position and encoder differ by more than a nonzero limit.
module asf_top #(
  parameter int unsigned STANDSTILL_CYCLES = asf_pkg::STANDSTILL_CYCLES
) (
  input wire logic clock, // 50 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic param_wr, // parameter write strobe
  input wire logic param_rd, // parameter read strobe
  input wire logic [7:0] param_num, // parameter number
  input wire logic [31:0] param_wdata, // parameter write value
  output var logic [31:0] param_rdata_reg, // parameter read value
  output var logic param_valid_reg, // one-cycle answer strobe
  output var logic param_error_reg, // unknown or read-only target
  input wire logic [6:0] drv_status, // asynchronous driver status pins
  input wire logic [9:0] load_value, // live load measurement
  input wire logic step_pulse, // one pulse per step
  input wire logic enc_up, // encoder count up pulse
  input wire logic enc_down, // encoder count down pulse
  input wire logic enc_zero, // encoder at zero position
  input wire logic motion_cmd, // motion command executed pulse
  input wire logic standby_zero, // standby current setting is zero
  input wire logic quiet_chopper, // voltage-mode quiet chopper active
  input wire logic [31:0] actual_position, // ramp position
  output var logic [1:0] coil_mode_reg, // applied standstill coil mode
  output var logic motor_stop_reg // deviation stop request
);
  logic [6:0] drv_sync;
  logic [1:0] coil_option_reg;
  logic [1:0] ext_flags_reg;
  logic [1:0] ext_flags_next;
  logic [31:0] enc_count_reg;
  logic zero_arm_reg;
  logic [31:0] max_dev_reg;
  logic [20:0] idle_cnt_reg;
  logic standstill_reg;
  logic [7:0] drv_flags;
  logic [32:0] dev_diff;
  logic [32:0] dev_abs;
  logic dev_exceeded;
  logic ext_read;
  logic [1:0] ext_set;
  logic wr_enc;
  logic wr_arm;

  asf_sync #(
    .W(7)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(drv_status),
    .dout(drv_sync)
  );

  assign drv_flags = {standstill_reg, drv_sync};
  assign ext_read = param_rd && (param_num == asf_pkg::NUM_EXT_FLAGS);
  assign wr_enc = param_wr && (param_num == asf_pkg::NUM_ENC_COUNT);
  assign wr_arm = param_wr && (param_num == asf_pkg::NUM_ZERO_CLEAR);
  assign dev_diff = {actual_position[31], actual_position}
    - {enc_count_reg[31], enc_count_reg};
  assign dev_abs = dev_diff[32] ? (33'h0_0000_0000 - dev_diff) : dev_diff;
  assign dev_exceeded = (max_dev_reg != 32'h0000_0000)
    && (dev_abs > {1'b0, max_dev_reg});

  // writable configuration
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      coil_option_reg <= asf_pkg::COIL_OPTION_RESET;
      max_dev_reg <= asf_pkg::MAX_DEV_RESET;
    end
    else if (param_wr)
    begin
      if (param_num == asf_pkg::NUM_COIL_OPTION)
        coil_option_reg <= param_wdata[1:0];
      if (param_num == asf_pkg::NUM_MAX_DEV)
        max_dev_reg <= {1'b0, param_wdata[30:0]};
    end
  end

  // gated coil mode
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      coil_mode_reg <= asf_pkg::ASF_COIL_NORMAL;
    else if (standby_zero && quiet_chopper)
      coil_mode_reg <= coil_option_reg;
    else
      coil_mode_reg <= asf_pkg::ASF_COIL_NORMAL;
  end

  // extended flags, a new event wins over the clear
  always_comb
  begin
    ext_set = 2'h0;
    ext_set[asf_pkg::EXT_STALL_BIT] = drv_sync[asf_pkg::DRV_STALL_BIT];
    ext_set[asf_pkg::EXT_DEV_BIT] = dev_exceeded;
    ext_flags_next = ext_flags_reg;
    if (ext_read || motion_cmd)
      ext_flags_next = 2'h0;
    ext_flags_next = ext_flags_next | ext_set;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ext_flags_reg <= 2'h0;
    else
      ext_flags_reg <= ext_flags_next;
  end

  // standstill detector
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      idle_cnt_reg <= 21'h00_0000;
      standstill_reg <= 1'b0;
    end
    else if (step_pulse)
    begin
      idle_cnt_reg <= 21'h00_0000;
      standstill_reg <= 1'b0;
    end
    else if (idle_cnt_reg >= 21'(STANDSTILL_CYCLES - 1))
      standstill_reg <= 1'b1;
    else
      idle_cnt_reg <= idle_cnt_reg + 21'h00_0001;
  end

  // encoder counter and clear-on-zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      enc_count_reg <= asf_pkg::ENC_COUNT_RESET;
    else if (wr_enc)
      enc_count_reg <= param_wdata;
    else if (zero_arm_reg && enc_zero)
      enc_count_reg <= 32'h0000_0000;
    else if (enc_up && !enc_down)
      enc_count_reg <= enc_count_reg + 32'h0000_0001;
    else if (enc_down && !enc_up)
      enc_count_reg <= enc_count_reg - 32'h0000_0001;
  end

  // software arming wins over the self clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      zero_arm_reg <= 1'b0;
    else if (wr_arm)
      zero_arm_reg <= param_wdata[0];
    else if (zero_arm_reg && enc_zero)
      zero_arm_reg <= 1'b0;
  end

  // deviation stop held until the next motion command
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      motor_stop_reg <= 1'b0;
    else if (dev_exceeded)
      motor_stop_reg <= 1'b1;
    else if (motion_cmd)
      motor_stop_reg <= 1'b0;
  end

  // parameter command answers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      param_rdata_reg <= 32'h0000_0000;
      param_valid_reg <= 1'b0;
      param_error_reg <= 1'b0;
    end
    else
    begin
      param_valid_reg <= param_rd || param_wr;
      param_error_reg <= 1'b0;
      param_rdata_reg <= 32'h0000_0000;
      if (param_rd)
      begin
        case (param_num)
          asf_pkg::NUM_COIL_OPTION: param_rdata_reg <= {30'h0, coil_option_reg};
          asf_pkg::NUM_LOAD: param_rdata_reg <= {22'h0, load_value};
          asf_pkg::NUM_EXT_FLAGS: param_rdata_reg <= {30'h0, ext_flags_reg};
          asf_pkg::NUM_DRV_FLAGS: param_rdata_reg <= {24'h0, drv_flags};
          asf_pkg::NUM_ENC_COUNT: param_rdata_reg <= enc_count_reg;
          asf_pkg::NUM_ZERO_CLEAR: param_rdata_reg <= {31'h0, zero_arm_reg};
          asf_pkg::NUM_MAX_DEV: param_rdata_reg <= max_dev_reg;
          default: param_error_reg <= 1'b1;
        endcase
      end
      else if (param_wr)
      begin
        case (param_num)
          asf_pkg::NUM_COIL_OPTION: param_error_reg <= 1'b0;
          asf_pkg::NUM_ENC_COUNT: param_error_reg <= 1'b0;
          asf_pkg::NUM_ZERO_CLEAR: param_error_reg <= 1'b0;
          asf_pkg::NUM_MAX_DEV: param_error_reg <= 1'b0;
          default: param_error_reg <= 1'b1; // read-only loads, flags
        endcase
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence arm_hit_s;
    zero_arm_reg && enc_zero && !wr_arm && !wr_enc;
  endsequence

  sequence cleared_s;
    (enc_count_reg == 32'h0000_0000) && !zero_arm_reg;
  endsequence

  chk_coil_option: assert property (
    standby_zero && quiet_chopper |=> coil_mode_reg == $past(coil_option_reg))
    else $error("coil mode does not follow option");
  chk_coil_gate: assert property (
    !(standby_zero && quiet_chopper) |=> coil_mode_reg == 2'h0)
    else $error("coil option applied while not gated");
  chk_load_read: assert property (
    param_rd && param_num == asf_pkg::NUM_LOAD
    |=> param_valid_reg && param_rdata_reg == {22'h0, $past(load_value)})
    else $error("load readout wrong");
  chk_ext_read: assert property (
    param_rd && param_num == asf_pkg::NUM_EXT_FLAGS
    |=> param_rdata_reg == {30'h0, $past(ext_flags_reg)})
    else $error("extended flags readout wrong");
  chk_ext_clear: assert property (
    (ext_read || motion_cmd) && ext_set == 2'h0 |=> ext_flags_reg == 2'h0)
    else $error("extended flags not cleared");
  chk_drv_read: assert property (
    param_rd && param_num == asf_pkg::NUM_DRV_FLAGS
    |=> param_rdata_reg[6:0] == $past(drv_sync))
    else $error("driver flags readout wrong");
  chk_drv_keep: assert property (
    param_rd && param_num == asf_pkg::NUM_DRV_FLAGS && !step_pulse
    && standstill_reg |=> standstill_reg)
    else $error("driver flag altered by read");
  chk_step_idle: assert property (
    step_pulse |=> !standstill_reg ##1 (idle_cnt_reg <= 21'h00_0001))
    else $error("standstill not cleared by step");
  chk_enc_write: assert property (
    wr_enc |=> enc_count_reg == $past(param_wdata))
    else $error("encoder write lost");
  chk_zero_clear: assert property (
    arm_hit_s |=> cleared_s)
    else $error("zero clear not performed");
  chk_arm_once: assert property (
    arm_hit_s ##1 (enc_zero && !wr_arm && !wr_enc && !enc_up && !enc_down)
    |=> enc_count_reg == 32'h0000_0000 && !zero_arm_reg)
    else $error("clear-on-zero stayed armed");
  chk_dev_stop: assert property (
    dev_exceeded |=> motor_stop_reg && ext_flags_reg[asf_pkg::EXT_DEV_BIT])
    else $error("deviation did not stop motor");
  chk_coil_read: assert property (
    param_rd && param_num == asf_pkg::NUM_COIL_OPTION
    |=> param_rdata_reg == {30'h0, $past(coil_option_reg)})
    else $error("coil option readout wrong");
  chk_ro_refused: assert property (
    param_wr && !param_rd && (param_num == asf_pkg::NUM_LOAD
    || param_num == asf_pkg::NUM_EXT_FLAGS || param_num == asf_pkg::NUM_DRV_FLAGS)
    |=> param_valid_reg && param_error_reg)
    else $error("write to read-only parameter accepted");
  chk_ext_stall: assert property (
    drv_sync[asf_pkg::DRV_STALL_BIT] |=> ext_flags_reg[asf_pkg::EXT_STALL_BIT])
    else $error("stall not latched in extended flags");
  chk_idle_set: assert property (
    !step_pulse && idle_cnt_reg >= 21'(STANDSTILL_CYCLES - 1) |=> standstill_reg)
    else $error("standstill not flagged after idle window");
  chk_idle_read: assert property (
    param_rd && param_num == asf_pkg::NUM_DRV_FLAGS
    |=> param_rdata_reg[7] == $past(standstill_reg))
    else $error("standstill bit readout wrong");
  chk_enc_step: assert property (
    enc_up && !enc_down && !wr_enc && !(zero_arm_reg && enc_zero)
    |=> enc_count_reg == $past(enc_count_reg) + 32'h0000_0001)
    else $error("encoder count did not step up");
  chk_arm_write: assert property (
    wr_arm |=> zero_arm_reg == $past(param_wdata[0]))
    else $error("clear-on-zero write lost");
  chk_stop_hold: assert property (
    motor_stop_reg && !motion_cmd |=> motor_stop_reg)
    else $error("deviation stop released early");
endmodule
`default_nettype wire

// file: asf_drv_model.sv
// partner model: motor driver stage and internal encoder front end
// assumes the bench sets its requests at falling edges; it answers at the next one
`timescale 1ns/1ps
`default_nettype none
module asf_drv_model (
  input wire logic clock, // system clock
  input wire logic [6:0] fault_req, // driver faults to present
  input wire logic [9:0] load_req, // load value to present
  input wire logic move_req, // one step per high cycle
  input wire logic move_up, // step direction
  input wire logic zero_req, // encoder passes its zero position
  output var logic [6:0] drv_status, // driver status pins
  output var logic [9:0] load_value, // load measurement
  output var logic step_pulse, // step pulse
  output var logic enc_up, // encoder count up
  output var logic enc_down, // encoder count down
  output var logic enc_zero // encoder at zero position
);
  // every step moves the encoder one count in the step direction
  always @(negedge clock)
  begin
    drv_status <= fault_req;
    load_value <= load_req;
    step_pulse <= move_req;
    enc_up <= move_req & move_up;
    enc_down <= move_req & ~move_up;
    enc_zero <= zero_req;
  end
endmodule
`default_nettype wire

// file: asf_top_tb_top.sv
// testbench for the axis status and fault parameter bank
// assumes asf_top with a short standstill window and the partner model
`timescale 1ns/1ps
`default_nettype none
module asf_top_tb_top;
  localparam int unsigned SS = 16;
  logic clock = 1'b0, rst_n = 1'b0, param_wr = 1'b0, param_rd = 1'b0;
  logic [7:0] param_num = 8'h00;
  logic [31:0] param_wdata = 32'h0, actual_position = 32'h0;
  logic motion_cmd = 1'b0, standby_zero = 1'b0, quiet_chopper = 1'b0;
  logic [6:0] fault_req = 7'h00;
  logic [9:0] load_req = 10'h000;
  logic move_req = 1'b0, move_up = 1'b0, zero_req = 1'b0;
  logic [31:0] param_rdata_reg;
  logic param_valid_reg, param_error_reg, motor_stop_reg, step_pulse;
  logic enc_up, enc_down, enc_zero;
  logic [1:0] coil_mode_reg;
  logic [6:0] drv_status;
  logic [9:0] load_value;
  int fail_count = 0;
  int num_checks = 0;
  always #10 clock = ~clock;
  asf_drv_model i_asf_drv_model (.clock(clock), .fault_req(fault_req), .load_req(load_req),
    .move_req(move_req), .move_up(move_up), .zero_req(zero_req), .drv_status(drv_status),
    .load_value(load_value), .step_pulse(step_pulse), .enc_up(enc_up), .enc_down(enc_down),
    .enc_zero(enc_zero));
  asf_top #(.STANDSTILL_CYCLES(SS)) i_asf_top (.clock(clock), .rst_n(rst_n),
    .param_wr(param_wr), .param_rd(param_rd), .param_num(param_num),
    .param_wdata(param_wdata), .param_rdata_reg(param_rdata_reg),
    .param_valid_reg(param_valid_reg), .param_error_reg(param_error_reg),
    .drv_status(drv_status), .load_value(load_value), .step_pulse(step_pulse),
    .enc_up(enc_up), .enc_down(enc_down), .enc_zero(enc_zero), .motion_cmd(motion_cmd),
    .standby_zero(standby_zero), .quiet_chopper(quiet_chopper),
    .actual_position(actual_position), .coil_mode_reg(coil_mode_reg),
    .motor_stop_reg(motor_stop_reg));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one command; the answer is judged in the cycle its strobe stands
  task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wdata,
    input logic [31:0] exp, input logic err);
    @(negedge clock);
    param_wr <= wr;
    param_rd <= ~wr;
    param_num <= num;
    param_wdata <= wdata;
    @(negedge clock);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
    check({31'h0, param_valid_reg}, 32'h1);
    check({31'h0, param_error_reg}, {31'h0, err});
    if (!wr)
      check(param_rdata_reg, exp);
  endtask
  task automatic rd(input logic [7:0] num, input logic [31:0] exp);
    access(1'b0, num, 32'h0, exp, 1'b0);
  endtask
  task automatic wr(input logic [7:0] num, input logic [31:0] data);
    access(1'b1, num, data, 32'h0, 1'b0);
  endtask
  task automatic move(input logic up, input int n);
    repeat (n)
    begin
      @(negedge clock);
      move_req <= 1'b1;
      move_up <= up;
      @(negedge clock);
      move_req <= 1'b0;
    end
    repeat (3) @(negedge clock);
  endtask
  task automatic test_access_kinds();
    rd(asf_pkg::NUM_COIL_OPTION, 32'h0);
    rd(asf_pkg::NUM_ENC_COUNT, 32'h0);
    access(1'b0, 8'h00, 32'h0, 32'h0, 1'b1);
    access(1'b1, asf_pkg::NUM_LOAD, 32'h5, 32'h0, 1'b1);
    access(1'b1, asf_pkg::NUM_EXT_FLAGS, 32'h3, 32'h0, 1'b1);
    load_req <= 10'h3FF;
    repeat (3) @(negedge clock);
    rd(asf_pkg::NUM_LOAD, 32'h0000_03FF);
  endtask
  task automatic test_coil();
    for (int v = 0; v < 4; v++)
    begin
      wr(asf_pkg::NUM_COIL_OPTION, 32'(v));
      rd(asf_pkg::NUM_COIL_OPTION, 32'(v));
      standby_zero <= 1'b1;
      quiet_chopper <= 1'b1;
      repeat (2) @(negedge clock);
      check({30'h0, coil_mode_reg}, 32'(v));
      quiet_chopper <= 1'b0;
      repeat (2) @(negedge clock);
      check({30'h0, coil_mode_reg}, 32'h0);
      standby_zero <= 1'b0;
      quiet_chopper <= 1'b1;
      repeat (2) @(negedge clock);
      check({30'h0, coil_mode_reg}, 32'h0);
    end
  endtask
  task automatic test_driver_flags();
    for (int b = 0; b < 7; b++)
    begin
      fault_req <= 7'(1 << b);
      move(1'b1, 1);
      rd(asf_pkg::NUM_DRV_FLAGS, 32'(1 << b));
      rd(asf_pkg::NUM_DRV_FLAGS, 32'(1 << b));
    end
    fault_req <= 7'h00;
    repeat (SS + 4) @(negedge clock);
    rd(asf_pkg::NUM_DRV_FLAGS, 32'h80);
    rd(asf_pkg::NUM_DRV_FLAGS, 32'h80);
  endtask
  task automatic test_ext_flags();
    wr(asf_pkg::NUM_ENC_COUNT, 32'h0);
    wr(asf_pkg::NUM_MAX_DEV, 32'h1);
    fault_req <= 7'h01;
    actual_position <= 32'h5;
    repeat (6) @(negedge clock);
    check({31'h0, motor_stop_reg}, 32'h1);
    fault_req <= 7'h00;
    actual_position <= 32'h0;
    repeat (6) @(negedge clock);
    rd(asf_pkg::NUM_EXT_FLAGS, 32'h3);
    rd(asf_pkg::NUM_EXT_FLAGS, 32'h0);
    actual_position <= 32'h5;
    repeat (3) @(negedge clock);
    actual_position <= 32'h0;
    repeat (2) @(negedge clock);
    motion_cmd <= 1'b1;
    @(negedge clock);
    motion_cmd <= 1'b0;
    repeat (2) @(negedge clock);
    check({31'h0, motor_stop_reg}, 32'h0);
    rd(asf_pkg::NUM_EXT_FLAGS, 32'h0);
    wr(asf_pkg::NUM_MAX_DEV, 32'h0);
  endtask
  task automatic test_encoder();
    wr(asf_pkg::NUM_ENC_COUNT, 32'h8000_0000);
    rd(asf_pkg::NUM_ENC_COUNT, 32'h8000_0000);
    move(1'b1, 3);
    move(1'b0, 1);
    rd(asf_pkg::NUM_ENC_COUNT, 32'h8000_0002);
    wr(asf_pkg::NUM_ENC_COUNT, 32'h7FFF_FFFF);
    rd(asf_pkg::NUM_ENC_COUNT, 32'h7FFF_FFFF);
    wr(asf_pkg::NUM_ZERO_CLEAR, 32'h1);
    rd(asf_pkg::NUM_ZERO_CLEAR, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      // zero held two cycles: the second hit must find the control disarmed
      @(negedge clock);
      zero_req <= 1'b1;
      repeat (2) @(negedge clock);
      zero_req <= 1'b0;
      repeat (2) @(negedge clock);
      rd(asf_pkg::NUM_ENC_COUNT, 32'(2 * k));
      rd(asf_pkg::NUM_ZERO_CLEAR, 32'h0);
      move(1'b1, 2);
    end
  endtask
  // a reset in mid-run returns the writable parameters to their reset values
  task automatic test_reset();
    wr(asf_pkg::NUM_ZERO_CLEAR, 32'h1);
    @(negedge clock);
    rst_n <= 1'b0;
    repeat (6) @(negedge clock);
    rst_n <= 1'b1;
    rd(asf_pkg::NUM_COIL_OPTION, 32'h0);
    rd(asf_pkg::NUM_ENC_COUNT, 32'h0);
    rd(asf_pkg::NUM_ZERO_CLEAR, 32'h0);
    check({31'h0, motor_stop_reg}, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clock);
    rst_n <= 1'b1;
    test_access_kinds();
    test_coil();
    test_driver_flags();
    test_ext_flags();
    test_encoder();
    test_reset();
    print_verdict();
  end
  // hang guard, well beyond the few hundred cycles the tests take
  initial
  begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
